// ---- logic/su_cfg.svh ----
// Register map, field positions, reset values and timing for the second serial port.
`ifndef SU_CFG_SVH
`define SU_CFG_SVH
`define SU_IDX_IE      8'hA8
`define SU_IDX_SADDR0  8'hA9
`define SU_IDX_PORT1_SLAVE_ADDRESS  8'hAA
`define SU_IDX_IP      8'hB8
`define SU_IDX_SADEN0  8'hB9
`define SU_IDX_PORT1_ADDRESS_MASK  8'hBA
`define SU_IDX_SCON    8'hC0
`define SU_IDX_SBUF    8'hC1
`define SU_IDX_PMR     8'hC4
`define SU_IDX_STATUS  8'hC5
`define SU_IDX_POWER_CONTROL_REG    8'hD7
`define SU_IE_ES1      6
`define SU_IP_PS1      6
`define SU_PC_BAUD2    7
`define SU_PC_FESEL    6
`define SU_REG_RST     8'h00
`define SU_CD_RST      2'h1
`define SU_CD_DIV4     2'h1
`define SU_M0_DIV_SLOW 12
`define SU_M0_DIV_FAST 4
`define SU_M2_CLK_SLOW 64
`define SU_M2_CLK_FAST 32
`define SU_OVERSAMPLE  16
`define SU_MID_TICK    4'h7
`define SU_LAST_TICK   4'hF
`endif

// ---- logic/su_pkg.sv ----
// Types shared by the second serial port.
package su_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} su_tx_state_t;
  typedef enum logic {RX_IDLE, RX_BITS} su_rx_state_t;
endpackage

// ---- logic/su_uart.sv ----
// Second serial port with masked address match and a classic Wishbone register slave.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "su_cfg.svh"
// Functional notes
// - Two mode bits pick one of four frames.
// - Top bit is mode or sticky framing error.
// - 11-bit multiproc: ninth bit 0 blocks receive.
// - 10-bit multiproc: bad stop blocks receive.
// - Sync shift clock is clk/12 or clk/4.
// - Receive starts only while receive enable set; clearing it aborts async receive but not a mode 0 byte.
// - Ninth transmitted bit comes from software.
// - Receive ninth field: ninth bit or stop.
// - Transmit flag timing; software clears it.
// - Receive flag timing; software clears it.
// - Data address: read receive, write transmit.
// - Mask bits select compared address bits.
// - All-zero mask accepts every address byte.
// - First port uses same masked compare.
// - Priority bit; top priority bit reads 1.
// - Switchback forces divide-by-4 on start bit.
// - Transmit activity high until transmit flag.
// - Interrupt reaches processor only when enabled.
module su_uart (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial pins and variable-rate tick.
  input  wire logic        rxd_i,
  output logic             rxd_o,
  output logic             rxd_oe_o,
  output logic             txd_o,
  input  wire logic        baud_tick_i,
  // First port address compare.
  input  wire logic [7:0]  p0_rx_byte_i,
  output logic             p0_addr_hit_o,
  // Interrupt and clock divider.
  output logic             irq_o,
  output logic             irq_high_prio_o,
  output logic      [1:0]  clock_div_o
);
  import su_pkg::*;

  logic [7:0] ie_reg, saddr0_reg, port1_slave_address_reg, saden0_reg, port1_address_mask_reg, power_control_reg_reg;
  logic [6:0] ip_reg;
  logic sm0_reg, sm1_reg, sm2_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg, fe_reg;
  logic [1:0] cd_reg;
  logic       swb_reg;
  logic [7:0] rxbuf_reg, txbuf_next;
  logic       ack_reg, hit0_reg;
  logic [31:0] dat_reg;
  logic [1:0] mode;
  logic req, wr;
  logic wr_scon, wr_sbuf;
  logic [7:0] rdat;

  assign mode = {sm0_reg, sm1_reg};
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign wr_scon = wr && wb_adr_i[9:2] == `SU_IDX_SCON;
  assign wr_sbuf = wr && wb_adr_i[9:2] == `SU_IDX_SBUF;
  assign txbuf_next = wb_dat_i[7:0];

  // Pin synchroniser; logic reads the second stage, and start detection also reads the third.
  logic rxd_m_reg, rxd_s_reg, rxd_d_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_m_reg <= 1'b1;
      rxd_s_reg <= 1'b1;
      rxd_d_reg <= 1'b1;
    end else begin
      rxd_m_reg <= rxd_i;
      rxd_s_reg <= rxd_m_reg;
      rxd_d_reg <= rxd_s_reg;
    end
  end

  // Oversample tick: fixed rate in mode 2, external tick in modes 1 and 3.
  localparam logic [1:0] M2_SLOW = 2'(`SU_M2_CLK_SLOW / `SU_OVERSAMPLE - 1);
  localparam logic [1:0] M2_FAST = 2'(`SU_M2_CLK_FAST / `SU_OVERSAMPLE - 1);
  localparam logic [3:0] M0_SLOW = 4'(`SU_M0_DIV_SLOW - 1);
  localparam logic [3:0] M0_FAST = 4'(`SU_M0_DIV_FAST - 1);
  logic [1:0] m2_cnt_reg, m2_lim;
  logic [3:0] m0_lim;
  logic       tick;
  assign m2_lim = power_control_reg_reg[`SU_PC_BAUD2] ? M2_FAST : M2_SLOW;
  assign m0_lim = sm2_reg ? M0_FAST : M0_SLOW;
  assign tick = (mode == 2'h2) ? (m2_cnt_reg == m2_lim) : baud_tick_i;
  always_ff @(posedge clk_i) begin
    if (rst_i || m2_cnt_reg == m2_lim) begin
      m2_cnt_reg <= 2'h0;
    end else begin
      m2_cnt_reg <= m2_cnt_reg + 2'h1;
    end
  end

  // Transmit engine; mode 0 also runs the synchronous receive.
  su_tx_state_t tx_state_reg;
  logic [10:0] tx_sr_reg;
  logic [3:0]  tx_bits_reg, tx_tcnt_reg;
  logic        tx_m0rx_reg, tx_act_reg, txd_reg, rxo_reg;
  logic        tx_shift, m0_end, ti_set, ri_set_s;
  assign tx_shift = tx_state_reg == TX_ASYNC && tick && tx_tcnt_reg == `SU_LAST_TICK;
  assign m0_end = tx_state_reg == TX_SYNC && tx_tcnt_reg == m0_lim;
  assign ti_set = (tx_shift && tx_bits_reg == 4'h2)
      || (m0_end && tx_bits_reg == 4'h1 && !tx_m0rx_reg);
  assign ri_set_s = m0_end && tx_bits_reg == 4'h1 && tx_m0rx_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg <= TX_IDLE;
      tx_sr_reg <= 11'h7FF;
      tx_bits_reg <= 4'h0;
      tx_tcnt_reg <= 4'h0;
      tx_m0rx_reg <= 1'b0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          tx_tcnt_reg <= 4'h0;
          if (wr_sbuf && mode != 2'h0) begin
            tx_state_reg <= TX_ASYNC;
            tx_sr_reg <= {1'b1, (mode == 2'h1) ? 1'b1 : tb8_reg, txbuf_next, 1'b0};
            tx_bits_reg <= (mode == 2'h1) ? 4'hA : 4'hB;
          end else if (wr_sbuf) begin
            tx_state_reg <= TX_SYNC;
            tx_sr_reg <= {3'h7, txbuf_next};
            tx_bits_reg <= 4'h8;
            tx_m0rx_reg <= 1'b0;
          end else if (mode == 2'h0 && ren_reg && !ri_reg) begin
            tx_state_reg <= TX_SYNC;
            tx_bits_reg <= 4'h8;
            tx_m0rx_reg <= 1'b1;
          end
        end
        TX_ASYNC: begin
          if (tick) begin
            tx_tcnt_reg <= tx_tcnt_reg + 4'h1;
          end
          if (tx_shift) begin
            tx_sr_reg <= {1'b1, tx_sr_reg[10:1]};
            tx_bits_reg <= tx_bits_reg - 4'h1;
            if (tx_bits_reg == 4'h1) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        TX_SYNC: begin
          tx_tcnt_reg <= m0_end ? 4'h0 : tx_tcnt_reg + 4'h1;
          if (m0_end) begin
            tx_sr_reg <= {tx_sr_reg[10:8], rxd_s_reg, tx_sr_reg[7:1]};
            tx_bits_reg <= tx_bits_reg - 4'h1;
            if (tx_bits_reg == 4'h1) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // Activity flag and registered pin drive.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_act_reg <= 1'b0;
      txd_reg <= 1'b1;
      rxo_reg <= 1'b0;
    end else begin
      if (ti_set) begin
        tx_act_reg <= 1'b0;
      end else if (tx_state_reg == TX_IDLE && wr_sbuf) begin
        tx_act_reg <= 1'b1;
      end
      if (tx_state_reg == TX_SYNC) begin
        txd_reg <= tx_tcnt_reg > (m0_lim >> 1);
        rxo_reg <= !tx_m0rx_reg;
      end else begin
        txd_reg <= (tx_state_reg == TX_ASYNC) ? tx_sr_reg[0] : 1'b1;
        rxo_reg <= 1'b0;
      end
    end
  end
  assign txd_o = txd_reg;
  assign rxd_o = tx_sr_reg[0];
  assign rxd_oe_o = rxo_reg;

  // Asynchronous receive engine.
  su_rx_state_t rx_state_reg;
  logic [9:0] rx_sr_reg;
  logic [3:0] rx_bits_reg, rx_tcnt_reg, rx_last;
  logic       rx_act_reg, rx_start, rx_mid, rx_evt, rx_ninth, rx_ok, hit1;
  logic       ri_set_a, fe_set;
  logic [7:0] rx_data;
  assign rx_start = rx_state_reg == RX_IDLE && mode != 2'h0 && ren_reg
      && rxd_d_reg && !rxd_s_reg;
  assign rx_mid = rx_state_reg == RX_BITS && tick && rx_tcnt_reg == `SU_MID_TICK;
  assign rx_last = (mode == 2'h1) ? 4'h9 : 4'hA;
  assign rx_evt = rx_mid && rx_bits_reg == rx_last && ren_reg;
  assign rx_data = (mode == 2'h1) ? rx_sr_reg[9:2] : rx_sr_reg[8:1];
  assign rx_ninth = (mode == 2'h1) ? rxd_s_reg : rx_sr_reg[9];
  assign hit1 = ((rx_data ^ port1_slave_address_reg) & port1_address_mask_reg) == 8'h00;
  assign rx_ok = (mode == 2'h1) ? (!sm2_reg || rxd_s_reg)
      : (!sm2_reg || (rx_ninth && hit1));
  assign ri_set_a = rx_evt && rx_ok;
  assign fe_set = rx_evt && !rxd_s_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_reg <= RX_IDLE;
      rx_sr_reg <= 10'h000;
      rx_bits_reg <= 4'h0;
      rx_tcnt_reg <= 4'h0;
      rx_act_reg <= 1'b0;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          rx_tcnt_reg <= 4'h0;
          rx_bits_reg <= 4'h0;
          if (rx_start) begin
            rx_state_reg <= RX_BITS;
            rx_act_reg <= 1'b1;
          end
        end
        RX_BITS: begin
          if (tick) begin
            rx_tcnt_reg <= rx_tcnt_reg + 4'h1;
          end
          if (!ren_reg || (rx_mid && rx_bits_reg == 4'h0 && rxd_s_reg) || rx_evt) begin
            rx_state_reg <= RX_IDLE;
            rx_act_reg <= 1'b0;
          end else if (rx_mid) begin
            rx_sr_reg <= {rxd_s_reg, rx_sr_reg[9:1]};
            rx_bits_reg <= rx_bits_reg + 4'h1;
          end
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // Receive register loads only together with the receive flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxbuf_reg <= `SU_REG_RST;
    end else if (ri_set_a) begin
      rxbuf_reg <= rx_data;
    end else if (ri_set_s) begin
      rxbuf_reg <= {rxd_s_reg, tx_sr_reg[7:1]};
    end
  end

  // Control register; hardware set wins over a software clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {sm0_reg, sm1_reg, sm2_reg, ren_reg, tb8_reg} <= 5'h00;
      {rb8_reg, ti_reg, ri_reg, fe_reg} <= 4'h0;
    end else begin
      if (wr_scon) begin
        {sm1_reg, sm2_reg, ren_reg, tb8_reg} <= wb_dat_i[6:3];
        if (!power_control_reg_reg[`SU_PC_FESEL]) begin
          sm0_reg <= wb_dat_i[7];
        end
      end
      fe_reg <= fe_set || ((wr_scon && power_control_reg_reg[`SU_PC_FESEL]) ? wb_dat_i[7] : fe_reg);
      ti_reg <= ti_set || (wr_scon ? wb_dat_i[1] : ti_reg);
      ri_reg <= ri_set_a || ri_set_s || (wr_scon ? wb_dat_i[0] : ri_reg);
      if (ri_set_a) begin
        rb8_reg <= rx_ninth;
      end else if (wr_scon) begin
        rb8_reg <= wb_dat_i[2];
      end
    end
  end

  // Other registers, switchback and first-port compare.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {ie_reg, saddr0_reg, port1_slave_address_reg} <= {3{`SU_REG_RST}};
      {saden0_reg, port1_address_mask_reg, power_control_reg_reg} <= {3{`SU_REG_RST}};
      ip_reg <= 7'h00;
      cd_reg <= `SU_CD_RST;
      swb_reg <= 1'b0;
      hit0_reg <= 1'b0;
    end else begin
      hit0_reg <= ((p0_rx_byte_i ^ saddr0_reg) & saden0_reg) == 8'h00;
      if (wr) begin
        case (wb_adr_i[9:2])
          `SU_IDX_IE: ie_reg <= wb_dat_i[7:0];
          `SU_IDX_SADDR0: saddr0_reg <= wb_dat_i[7:0];
          `SU_IDX_PORT1_SLAVE_ADDRESS: port1_slave_address_reg <= wb_dat_i[7:0];
          `SU_IDX_IP: ip_reg <= wb_dat_i[6:0];
          `SU_IDX_SADEN0: saden0_reg <= wb_dat_i[7:0];
          `SU_IDX_PORT1_ADDRESS_MASK: port1_address_mask_reg <= wb_dat_i[7:0];
          `SU_IDX_POWER_CONTROL_REG: power_control_reg_reg <= {wb_dat_i[7:6], 6'h00};
          `SU_IDX_PMR: swb_reg <= wb_dat_i[5];
          default: ;
        endcase
      end
      if (rx_start && swb_reg) begin
        cd_reg <= `SU_CD_DIV4;
      end else if (wr && wb_adr_i[9:2] == `SU_IDX_PMR
          && !(swb_reg && (tx_act_reg || rx_act_reg))) begin
        cd_reg <= wb_dat_i[7:6];
      end
    end
  end

  // Read mux; the data address reads the receive register.
  always_comb begin
    case (wb_adr_i[9:2])
      `SU_IDX_IE: rdat = ie_reg;
      `SU_IDX_SADDR0: rdat = saddr0_reg;
      `SU_IDX_PORT1_SLAVE_ADDRESS: rdat = port1_slave_address_reg;
      `SU_IDX_IP: rdat = {1'b1, ip_reg};
      `SU_IDX_SADEN0: rdat = saden0_reg;
      `SU_IDX_PORT1_ADDRESS_MASK: rdat = port1_address_mask_reg;
      `SU_IDX_SCON: rdat = {power_control_reg_reg[`SU_PC_FESEL] ? fe_reg : sm0_reg, sm1_reg, sm2_reg,
          ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg};
      `SU_IDX_SBUF: rdat = rxbuf_reg;
      `SU_IDX_PMR: rdat = {cd_reg, swb_reg, 5'h00};
      `SU_IDX_STATUS: rdat = {4'h0, tx_act_reg, rx_act_reg, 2'h0};
      `SU_IDX_POWER_CONTROL_REG: rdat = power_control_reg_reg;
      default: rdat = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      dat_reg <= req ? {24'h00_0000, rdat} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign p0_addr_hit_o = hit0_reg;
  assign irq_o = ie_reg[`SU_IE_ES1] && (ti_reg || ri_reg);
  assign irq_high_prio_o = ip_reg[`SU_IP_PS1];
  assign clock_div_o = cd_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ip_read;
    s_req ##0 (!wb_we_i && wb_adr_i[9:2] == `SU_IDX_IP);
  endsequence

  a_wb_ack: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");
  a_ip_top: assert property (s_ip_read |=> wb_dat_o[7])
    else $error("priority top bit not read as one");
  a_irq_gate: assert property (($rose(ri_reg) || $rose(ti_reg)) |-> irq_o == ie_reg[6])
    else $error("interrupt not gated by enable");
  a_ti_hold: assert property (ti_reg && !wr_scon |=> ti_reg)
    else $error("transmit flag cleared by hardware");
  a_ri_hold: assert property (ri_reg && !wr_scon |=> ri_reg)
    else $error("receive flag cleared by hardware");
  a_tx_act_clr: assert property (ti_set |=> ti_reg && !tx_act_reg)
    else $error("transmit activity not cleared with flag");
  a_rx_off: assert property (!ren_reg |=> rx_state_reg == RX_IDLE)
    else $error("reception while disabled");
  a_mp_ninth: assert property (ri_set_a && mode[1] && sm2_reg |-> rx_ninth && hit1)
    else $error("receive flag despite ninth bit zero");
  a_mp_stop: assert property (ri_set_a && mode == 2'h1 && sm2_reg |-> rxd_s_reg)
    else $error("receive flag despite bad stop bit");
  a_mask_zero: assert property (rx_evt && mode[1] && rx_ninth && port1_address_mask_reg == 8'h00
      |-> ri_set_a)
    else $error("zero mask rejected an address");
  a_rx_load: assert property (ri_set_a |=> ri_reg && rxbuf_reg == $past(rx_data))
    else $error("receive register not loaded with flag");
  a_switchback: assert property (rx_start && swb_reg |=> cd_reg == `SU_CD_DIV4)
    else $error("switchback did not force divide by four");
  a_fe_set: assert property (fe_set |=> fe_reg)
    else $error("framing error not flagged");
endmodule
`default_nettype wire

// ---- tb/su_node.sv ----
// Remote serial node that sends frames to the port and captures frames from it.
`timescale 1ns/1ns
`default_nettype none
module su_node (
  // Clock.
  input  wire logic clk_i,
  // Line driven by the port and line driven into the port.
  input  wire logic line_i,
  output logic      line_o
);
  localparam int BIT_T = 32;
  logic [7:0]  got_byte;
  logic        got_ninth;
  logic        got_stop;
  int          got_n = 0;
  logic [10:0] shf;

  // The line idles high between frames.
  initial line_o = 1'b1;

  // Sends start, data LSB first, optional ninth bit, then the given stop level.
  task automatic send(input logic [7:0] d, input logic ninth, input logic stop,
                      input logic nine_en);
    logic [10:0] f;
    int          i;
    f = nine_en ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (i = 0; i < (nine_en ? 11 : 10); i++) begin
      line_o <= f[i];
      repeat (BIT_T) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask

  // Samples each bit of an 11-bit frame in its middle.
  always begin
    @(negedge line_i);
    repeat (BIT_T / 2) @(posedge clk_i);
    shf[0] = line_i;
    for (int b = 1; b < 11; b++) begin
      repeat (BIT_T) @(posedge clk_i);
      shf[b] = line_i;
    end
    got_byte = shf[8:1];
    got_ninth = shf[9];
    got_stop = shf[10];
    got_n++;
  end
endmodule
`default_nettype wire

// ---- tb/su_uart_tb.sv ----
// Self-checking bench for the second serial port.
`timescale 1ns/1ns
`default_nettype none
`include "su_cfg.svh"
module su_uart_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [9:0]  wb_adr = 10'h000;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] rdat;
  logic        ack, txd, rxd_o, rxd_oe, node_line, irq, hprio, p0_hit;
  logic        tick = 1'b0;
  logic [1:0]  cdiv;
  logic [7:0]  p0_byte = 8'h00;
  wire logic   rxd_w;
  int          error_cnt = 0;
  int          n_checks = 0;

  assign rxd_w = rxd_oe ? rxd_o : node_line;
  always #5 clk_i = ~clk_i;
  // A 16x tick every second clock gives 32 clocks per bit in the variable-rate modes.
  always @(posedge clk_i) tick <= ~tick;

  su_uart dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rxd_i(rxd_w), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe),
    .txd_o(txd), .baud_tick_i(tick), .p0_rx_byte_i(p0_byte), .p0_addr_hit_o(p0_hit),
    .irq_o(irq), .irq_high_prio_o(hprio), .clock_div_o(cdiv));
  su_node node (.clk_i(clk_i), .line_i(txd), .line_o(node_line));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {idx, 2'h0};
    wb_dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] m,
                        input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, idx, 8'h00, q);
    chk(nm, q & {24'h0, m}, {24'h0, e});
  endtask

  // Collects what the port shifts out in synchronous mode, one bit per rising shift clock.
  logic [7:0] m0_sr = 8'h00;
  logic       txd_q = 1'b1;
  int         cyc_n = 0;
  int         m0_n = 0;
  int         m0_t0 = 0;
  int         m0_t1 = 0;
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    txd_q <= txd;
    if (rxd_oe && txd && !txd_q) begin
      m0_sr <= {rxd_o, m0_sr[7:1]};
      m0_n <= m0_n + 1;
      m0_t1 <= cyc_n;
      if (m0_n % 8 == 0) begin
        m0_t0 <= cyc_n;
      end
    end
  end

  // Shifts one byte out in synchronous mode and checks data, shift clock period and flag.
  task automatic m0_tx(input logic [7:0] scon, input logic [7:0] d, input int per);
    int n0;
    wr(`SU_IDX_SCON, scon);
    n0 = m0_n;
    wr(`SU_IDX_SBUF, d);
    wait (m0_n == n0 + 8);
    repeat (per) @(posedge clk_i);
    chk("m0_data", m0_sr, d);
    chk("m0_period", m0_t1 - m0_t0, 7 * per);
    chk("m0_oe", rxd_oe, 1'b0);
    rd_chk("m0_ti", `SU_IDX_SCON, 8'h02, 8'h02);
  endtask

  task wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    wrap_up;
  end

  initial begin
    int n;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("prio_reg", `SU_IDX_IP, 8'hFF, 8'h80);
    rd_chk("hole", 8'h00, 8'hFF, 8'h00);
    wr(`SU_IDX_IP, 8'h40);
    rd_chk("prio_reg", `SU_IDX_IP, 8'hFF, 8'hC0);
    chk("high_prio", hprio, 1'b1);
    wr(`SU_IDX_SADDR0, 8'h5A);
    wr(`SU_IDX_SADEN0, 8'hF0);
    p0_byte <= 8'h53;
    repeat (2) @(posedge clk_i);
    chk("p0_hit", p0_hit, 1'b1);
    p0_byte <= 8'h43;
    repeat (2) @(posedge clk_i);
    chk("p0_hit", p0_hit, 1'b0);
    wr(`SU_IDX_SADEN0, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("p0_hit", p0_hit, 1'b1);
    // Transmit one 11-bit frame at 32 clocks per bit.
    wr(`SU_IDX_POWER_CONTROL_REG, 8'h80);
    wr(`SU_IDX_SCON, 8'h88);
    n = node.got_n;
    wr(`SU_IDX_SBUF, 8'hA5);
    rd_chk("status", `SU_IDX_STATUS, 8'h08, 8'h08);
    wait (node.got_n != n);
    @(posedge clk_i);
    chk("tx_byte", node.got_byte, 8'hA5);
    chk("tx_ninth", node.got_ninth, 1'b1);
    chk("tx_stop", node.got_stop, 1'b1);
    rd_chk("ctrl", `SU_IDX_SCON, 8'hFF, 8'h8A);
    rd_chk("status", `SU_IDX_STATUS, 8'h08, 8'h00);
    rd_chk("data", `SU_IDX_SBUF, 8'hFF, 8'h00);
    chk("irq", irq, 1'b0);
    wr(`SU_IDX_IE, 8'h40);
    chk("irq", irq, 1'b1);
    // Receive with switchback armed.
    wr(`SU_IDX_PMR, 8'hA0);
    chk("clock_div", cdiv, 2'h2);
    wr(`SU_IDX_SCON, 8'h90);
    node.send(8'h3C, 1'b1, 1'b1, 1'b1);
    chk("clock_div", cdiv, 2'h1);
    rd_chk("ctrl", `SU_IDX_SCON, 8'hFF, 8'h95);
    rd_chk("data", `SU_IDX_SBUF, 8'hFF, 8'h3C);
    // Multiprocessor filtering with an open and a narrow mask.
    wr(`SU_IDX_PORT1_ADDRESS_MASK, 8'h00);
    wr(`SU_IDX_SCON, 8'hB0);
    node.send(8'h11, 1'b0, 1'b1, 1'b1);
    rd_chk("ri", `SU_IDX_SCON, 8'h01, 8'h00);
    rd_chk("data", `SU_IDX_SBUF, 8'hFF, 8'h3C);
    node.send(8'h22, 1'b1, 1'b1, 1'b1);
    rd_chk("ri", `SU_IDX_SCON, 8'h01, 8'h01);
    wr(`SU_IDX_PORT1_SLAVE_ADDRESS, 8'h50);
    wr(`SU_IDX_PORT1_ADDRESS_MASK, 8'hF0);
    rd_chk("mask1", `SU_IDX_PORT1_ADDRESS_MASK, 8'hFF, 8'hF0);
    wr(`SU_IDX_SCON, 8'hB0);
    node.send(8'h6F, 1'b1, 1'b1, 1'b1);
    rd_chk("ri", `SU_IDX_SCON, 8'h01, 8'h00);
    node.send(8'h5F, 1'b1, 1'b1, 1'b1);
    rd_chk("data", `SU_IDX_SBUF, 8'hFF, 8'h5F);
    // Receiver disabled.
    wr(`SU_IDX_SCON, 8'h80);
    node.send(8'h33, 1'b1, 1'b1, 1'b1);
    rd_chk("ri", `SU_IDX_SCON, 8'h01, 8'h00);
    rd_chk("data", `SU_IDX_SBUF, 8'hFF, 8'h5F);
    // Ten-bit frames on the tick rate.
    wr(`SU_IDX_SCON, 8'h70);
    node.send(8'h44, 1'b0, 1'b0, 1'b0);
    rd_chk("ri", `SU_IDX_SCON, 8'h01, 8'h00);
    wr(`SU_IDX_SCON, 8'h50);
    node.send(8'h55, 1'b0, 1'b1, 1'b0);
    rd_chk("ctrl", `SU_IDX_SCON, 8'hFF, 8'h55);
    rd_chk("data", `SU_IDX_SBUF, 8'hFF, 8'h55);
    // Framing error flag on a low stop bit.
    wr(`SU_IDX_SCON, 8'h90);
    wr(`SU_IDX_POWER_CONTROL_REG, 8'hC0);
    wr(`SU_IDX_SCON, 8'h10);
    rd_chk("frame_err", `SU_IDX_SCON, 8'h80, 8'h00);
    node.send(8'h66, 1'b1, 1'b0, 1'b1);
    rd_chk("frame_err", `SU_IDX_SCON, 8'h80, 8'h80);
    // Synchronous mode at both shift rates, then one receive from the idle line.
    wr(`SU_IDX_POWER_CONTROL_REG, 8'h00);
    m0_tx(8'h00, 8'h96, 12);
    m0_tx(8'h20, 8'h3B, 4);
    wr(`SU_IDX_SCON, 8'h10);
    repeat (8 * 12 + 8) @(posedge clk_i);
    rd_chk("ri", `SU_IDX_SCON, 8'h01, 8'h01);
    rd_chk("data", `SU_IDX_SBUF, 8'hFF, 8'hFF);
    wrap_up;
  end
endmodule
`default_nettype wire
